// file: hdl/fhc_params.svh
`ifndef FHC_PARAMS_SVH
`define FHC_PARAMS_SVH

// clock rate
`define FHC_CLK_MHZ      20
// bus widths
`define FHC_ADDR_W       17
`define FHC_DATA_W       8
// read cycle minimum, fastest grade, ns
`define FHC_T_RC_NS      45
// write cycle minimum, fastest grade, ns
`define FHC_T_WC_NS      45
// write or select strobe low width, ns
`define FHC_T_WP_NS      25
// write or select strobe high width, ns
`define FHC_T_WPH_NS     20
// output enable high between status reads, ns
`define FHC_T_OEH_NS     10
// byte program longest time, us
`define FHC_T_PROG_US    300
// erase longest time, s
`define FHC_T_ERASE_S    15
// status bit positions
`define FHC_TIMEOUT_BIT  5
`define FHC_TOGGLE_BIT   6
`define FHC_POLLING_BIT  7
// program command sequence, plain defaults
`define FHC_UNLOCK_A1    17'h05555
`define FHC_UNLOCK_A2    17'h02aaa
`define FHC_UNLOCK_D1    8'haa
`define FHC_UNLOCK_D2    8'h55
`define FHC_PROG_CODE    8'ha0
// number of bus writes in a program command
`define FHC_PROG_WRITES  4
// pin synchroniser depth
`define FHC_SYNC_STAGES  2
// reset values of the strobes and the data driver
`define FHC_STROBE_RST   1'b1
`define FHC_DRIVE_RST    1'b0

`endif

// file: hdl/fhc_pkg.sv
package fhc_pkg;
  // user command codes
  typedef enum logic [1:0] {
    fhc_op_read  = 2'h0,
    fhc_op_write = 2'h1,
    fhc_op_prog  = 2'h2,
    fhc_op_poll  = 2'h3
  } fhc_op_type;

  // result codes
  typedef enum logic [1:0] {
    fhc_st_ok       = 2'h0,
    fhc_st_dev_fail = 2'h1,
    fhc_st_host_to  = 2'h2
  } fhc_status_type;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    fhc_s_idle  = 6'h01,
    fhc_s_write = 6'h02,
    fhc_s_pa    = 6'h04,
    fhc_s_pb    = 6'h08,
    fhc_s_final = 6'h10,
    fhc_s_done  = 6'h20
  } fhc_seq_type;

  // bus cycle engine states, one-hot
  typedef enum logic [2:0] {
    fhc_e_idle = 3'h1,
    fhc_e_act  = 3'h2,
    fhc_e_rec  = 3'h4
  } fhc_eng_type;
endpackage

// file: hdl/fhc_cyc_if.sv
`include "fhc_params.svh"

interface fhc_cyc_if;
  logic                     req;
  logic                     ready;
  logic                     is_write;
  logic                     status_read;
  logic [`FHC_ADDR_W-1:0]   addr;
  logic [`FHC_DATA_W-1:0]   wdata;
  logic                     done;
  logic [`FHC_DATA_W-1:0]   rdata;

  modport seq (output req, is_write, status_read, addr, wdata,
               input ready, done, rdata);
  modport eng (input req, is_write, status_read, addr, wdata,
               output ready, done, rdata);
endinterface

// file: hdl/fhc_cycle.sv
`include "fhc_params.svh"

module fhc_cycle #(
  parameter int T_RC_NS  = `FHC_T_RC_NS,
  parameter int T_WC_NS  = `FHC_T_WC_NS,
  parameter int T_WP_NS  = `FHC_T_WP_NS,
  parameter int T_WPH_NS = `FHC_T_WPH_NS,
  parameter int T_OEH_NS = `FHC_T_OEH_NS
) (
  input  wire logic                   clock,     // system clock
  input  wire logic                   rst,       // sync reset
  fhc_cyc_if.eng                      cyc,       // cycle requests
  output logic                        flash_ce_n, // chip select
  output logic                        flash_oe_n, // output enable
  output logic                        flash_we_n, // write strobe
  output logic [`FHC_ADDR_W-1:0]      flash_addr, // address pins
  output logic [`FHC_DATA_W-1:0]      flash_dq_out, // data driven
  output logic                        flash_dq_oe,  // data drive enable
  input  wire logic [`FHC_DATA_W-1:0] flash_dq_in   // data sensed
);
  // minimum times rounded up to whole cycles, never below one
  function automatic int cyc_of(input int ns);
    int c;
    c = (ns * `FHC_CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC  = cyc_of(T_RC_NS) + `FHC_SYNC_STAGES;
  localparam int WP_CYC  = cyc_of(T_WP_NS);
  localparam int WPH_CYC = cyc_of(T_WPH_NS);
  localparam int WC_REST = cyc_of(T_WC_NS) - WP_CYC;
  localparam int WR_REC  = (WC_REST > WPH_CYC) ? WC_REST : WPH_CYC;
  localparam int OEH_CYC = cyc_of(T_OEH_NS);

  if (RD_CYC > 255 || WR_REC > 255 || WP_CYC > 255 || OEH_CYC > 255) begin : g_chk
    $error("fhc_cycle: strobe counts exceed counter width");
  end

  fhc_pkg::fhc_eng_type    state;
  fhc_pkg::fhc_eng_type    next_state;
  logic [7:0]              cnt;
  logic [7:0]              next_cnt;
  logic                    wr;
  logic                    stat;
  logic [`FHC_DATA_W-1:0]  sync0;
  logic [`FHC_DATA_W-1:0]  sync1;

  // count decode and strobe windows
  wire cnt_zero = (cnt == 8'h00);
  wire in_act   = (state == fhc_pkg::fhc_e_act);
  wire in_rec   = (state == fhc_pkg::fhc_e_rec);
  wire [7:0] act_load = cyc.is_write ? 8'(WP_CYC - 1) : 8'(RD_CYC - 1);
  wire [7:0] rec_load = wr ? 8'(WR_REC - 1) : (stat ? 8'(OEH_CYC - 1) : 8'h00);
  assign cyc.ready = (state == fhc_pkg::fhc_e_idle);
  assign cyc.done  = in_rec && cnt_zero;

  // write flag as seen by the next cycle
  wire next_wr = (cyc.ready && cyc.req) ? cyc.is_write : wr;

  // engine next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      fhc_pkg::fhc_e_idle: begin
        if (cyc.req) begin
          next_state = fhc_pkg::fhc_e_act;
          next_cnt   = act_load;
        end
      end
      fhc_pkg::fhc_e_act: begin
        if (cnt_zero) begin
          next_state = fhc_pkg::fhc_e_rec;
          next_cnt   = rec_load;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      fhc_pkg::fhc_e_rec: begin
        if (cnt_zero) begin
          next_state = fhc_pkg::fhc_e_idle;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
    endcase
  end

  // two-stage pin synchroniser
  always_ff @(posedge clock) begin
    sync0 <= flash_dq_in;
    sync1 <= sync0;
  end

  // state, latched request and strobes; both strobes fall and rise together
  always_ff @(posedge clock) begin
    if (rst) begin
      state        <= fhc_pkg::fhc_e_idle;
      cnt          <= 8'h00;
      wr           <= 1'b0;
      stat         <= 1'b0;
      flash_ce_n   <= `FHC_STROBE_RST;
      flash_oe_n   <= `FHC_STROBE_RST;
      flash_we_n   <= `FHC_STROBE_RST;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_dq_oe  <= `FHC_DRIVE_RST;
      cyc.rdata    <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (cyc.ready && cyc.req) begin
        wr           <= cyc.is_write;
        stat         <= cyc.status_read;
        flash_addr   <= cyc.addr;
        flash_dq_out <= cyc.wdata;
      end
      flash_ce_n  <= !(next_state == fhc_pkg::fhc_e_act);
      flash_we_n  <= !(next_state == fhc_pkg::fhc_e_act && next_wr);
      flash_oe_n  <= !(next_state == fhc_pkg::fhc_e_act && !next_wr);
      flash_dq_oe <= (next_state != fhc_pkg::fhc_e_idle) && next_wr;
      if (in_act && cnt_zero && !wr) begin
        cyc.rdata <= sync1;
      end
    end
  end

endmodule // fhc_cycle

// file: hdl/fhc_host.sv
// Operation
// - read cycle held at least grade minimum
// - output enable high gap between status reads
// - write cycle lasts at least grade minimum
// - write strobe low and high minimum widths
// - chip select low and high minimum widths
// - program byte uses four bus writes
`include "fhc_params.svh"

module fhc_host #(
  parameter int T_RC_NS    = `FHC_T_RC_NS,
  parameter int T_WC_NS    = `FHC_T_WC_NS,
  parameter int T_WP_NS    = `FHC_T_WP_NS,
  parameter int T_WPH_NS   = `FHC_T_WPH_NS,
  parameter int T_OEH_NS   = `FHC_T_OEH_NS,
  parameter int PROG_LIMIT = `FHC_T_PROG_US * `FHC_CLK_MHZ,
  parameter int ERASE_LIMIT = `FHC_T_ERASE_S * `FHC_CLK_MHZ * 1000000
) (
  input  wire logic                   clock,        // system clock
  input  wire logic                   rst,          // sync reset
  input  wire logic                   cmd_valid,    // command offered
  output logic                        cmd_ready,    // command taken
  input  wire fhc_pkg::fhc_op_type    cmd_op,       // command code
  input  wire logic [`FHC_ADDR_W-1:0] cmd_addr,     // target address
  input  wire logic [`FHC_DATA_W-1:0] cmd_data,     // write data
  output logic                        rsp_valid,    // result pulse
  output logic [`FHC_DATA_W-1:0]      rsp_data,     // data read back
  output fhc_pkg::fhc_status_type     rsp_status,   // result code
  output logic                        busy,         // command in progress
  output logic                        flash_ce_n,   // chip select
  output logic                        flash_oe_n,   // output enable
  output logic                        flash_we_n,   // write strobe
  output logic [`FHC_ADDR_W-1:0]      flash_addr,   // address pins
  output logic [`FHC_DATA_W-1:0]      flash_dq_out, // data driven
  output logic                        flash_dq_oe,  // data drive enable
  input  wire logic [`FHC_DATA_W-1:0] flash_dq_in   // data sensed
);
  if (PROG_LIMIT < 1 || ERASE_LIMIT < 1 || PROG_LIMIT > ERASE_LIMIT) begin : g_chk
    $error("fhc_host: poll limits out of range");
  end

  fhc_cyc_if cyc ();

  fhc_cycle #(
    .T_RC_NS  (T_RC_NS),
    .T_WC_NS  (T_WC_NS),
    .T_WP_NS  (T_WP_NS),
    .T_WPH_NS (T_WPH_NS),
    .T_OEH_NS (T_OEH_NS)
  ) u_cycle (
    .clock        (clock),
    .rst          (rst),
    .cyc          (cyc),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in)
  );

  fhc_pkg::fhc_seq_type    state;
  fhc_pkg::fhc_seq_type    next_state;
  fhc_pkg::fhc_op_type     op;
  fhc_pkg::fhc_status_type status;
  logic [`FHC_ADDR_W-1:0]  addr;
  logic [`FHC_DATA_W-1:0]  data;
  logic [1:0]              step;
  logic                    issued;
  logic                    to_seen;
  logic [`FHC_DATA_W-1:0]  first;
  logic [31:0]             budget;

  // program command table; raw writes and the last program write carry the command's own
  wire raw_or_last = (op != fhc_pkg::fhc_op_prog) ||
                     (step == 2'(`FHC_PROG_WRITES - 1));
  wire [`FHC_ADDR_W-1:0] seq_addr = raw_or_last ? addr :
                                    (step == 2'd1) ? `FHC_UNLOCK_A2 : `FHC_UNLOCK_A1;
  wire [`FHC_DATA_W-1:0] seq_data = raw_or_last ? data :
                                    (step == 2'd0) ? `FHC_UNLOCK_D1 :
                                    (step == 2'd1) ? `FHC_UNLOCK_D2 : `FHC_PROG_CODE;
  wire last_step = (op != fhc_pkg::fhc_op_prog) ||
                   (step == 2'(`FHC_PROG_WRITES - 1));

  // status decode of the second of two reads
  wire        toggled  = first[`FHC_TOGGLE_BIT] != cyc.rdata[`FHC_TOGGLE_BIT];
  wire        dev_to   = cyc.rdata[`FHC_TIMEOUT_BIT];
  wire        pol_ok   = cyc.rdata[`FHC_POLLING_BIT] == data[`FHC_POLLING_BIT];
  wire        out_time = (budget == 32'h0);
  wire [31:0] limit    = (op == fhc_pkg::fhc_op_prog) ? 32'(PROG_LIMIT) :
                         32'(ERASE_LIMIT);

  // bus cycle requests
  wire in_write = (state == fhc_pkg::fhc_s_write);
  wire in_read  = (state == fhc_pkg::fhc_s_pa) || (state == fhc_pkg::fhc_s_pb) ||
                  (state == fhc_pkg::fhc_s_final);
  assign cyc.req         = (in_write || in_read) && !issued;
  assign cyc.is_write    = in_write;
  assign cyc.status_read = (state == fhc_pkg::fhc_s_pa) ||
                           (state == fhc_pkg::fhc_s_pb);
  assign cyc.addr        = in_write ? seq_addr : addr;
  assign cyc.wdata       = seq_data;
  assign cmd_ready       = (state == fhc_pkg::fhc_s_idle);
  assign busy            = !cmd_ready;

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      fhc_pkg::fhc_s_idle: begin
        if (cmd_valid) begin
          unique case (cmd_op)
            fhc_pkg::fhc_op_read: next_state = fhc_pkg::fhc_s_final;
            fhc_pkg::fhc_op_poll: next_state = fhc_pkg::fhc_s_pa;
            fhc_pkg::fhc_op_write,
            fhc_pkg::fhc_op_prog: next_state = fhc_pkg::fhc_s_write;
          endcase
        end
      end
      fhc_pkg::fhc_s_write: begin
        if (cyc.done && last_step) begin
          next_state = (op == fhc_pkg::fhc_op_prog) ? fhc_pkg::fhc_s_pa :
                       fhc_pkg::fhc_s_done;
        end
      end
      fhc_pkg::fhc_s_pa: begin
        if (cyc.done) begin
          next_state = fhc_pkg::fhc_s_pb;
        end
      end
      fhc_pkg::fhc_s_pb: begin
        if (cyc.done) begin
          if (!toggled) begin
            next_state = fhc_pkg::fhc_s_final;
          end else if ((to_seen || out_time)) begin
            next_state = fhc_pkg::fhc_s_done;
          end else begin
            next_state = fhc_pkg::fhc_s_pa;
          end
        end
      end
      fhc_pkg::fhc_s_final: begin
        if (cyc.done) begin
          next_state = fhc_pkg::fhc_s_done;
        end
      end
      fhc_pkg::fhc_s_done: begin
        next_state = fhc_pkg::fhc_s_idle;
      end
      default: begin
        next_state = fhc_pkg::fhc_s_idle;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state   <= fhc_pkg::fhc_s_idle;
      op      <= fhc_pkg::fhc_op_read;
      status  <= fhc_pkg::fhc_st_ok;
      addr    <= '0;
      data    <= '0;
      step    <= 2'd0;
      issued  <= 1'b0;
      to_seen <= 1'b0;
      first   <= '0;
      budget  <= 32'h0;
    end else begin
      state <= next_state;
      if (cyc.req && cyc.ready) begin
        issued <= 1'b1;
      end else if (cyc.done) begin
        issued <= 1'b0;
      end
      if (cmd_ready && cmd_valid) begin
        op      <= cmd_op;
        addr    <= cmd_addr;
        data    <= cmd_data;
        step    <= 2'd0;
        to_seen <= 1'b0;
        status  <= fhc_pkg::fhc_st_ok;
        budget  <= (cmd_op == fhc_pkg::fhc_op_prog) ? 32'(PROG_LIMIT) : 32'(ERASE_LIMIT);
      end else if (busy && !out_time) begin
        budget <= budget - 32'h1;
      end
      if (in_write && cyc.done) begin
        step <= step + 2'd1;
      end
      if (state == fhc_pkg::fhc_s_pa && cyc.done) begin
        first <= cyc.rdata;
      end
      // device timeout: re-read once, fail if still toggling
      if (state == fhc_pkg::fhc_s_pb && cyc.done && toggled) begin
        if (dev_to) begin
          to_seen <= 1'b1;
        end
        if (to_seen) begin
          status <= fhc_pkg::fhc_st_dev_fail;
        end else if (out_time) begin
          status <= fhc_pkg::fhc_st_host_to;
        end
      end
      if (state == fhc_pkg::fhc_s_final && cyc.done &&
          op == fhc_pkg::fhc_op_prog && !pol_ok) begin
        status <= fhc_pkg::fhc_st_dev_fail;
      end
      if (limit == 32'h0) begin
        status <= fhc_pkg::fhc_st_host_to;
      end
    end
  end

  // result outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid  <= 1'b0;
      rsp_data   <= '0;
      rsp_status <= fhc_pkg::fhc_st_ok;
    end else begin
      rsp_valid <= (state == fhc_pkg::fhc_s_done);
      if (state == fhc_pkg::fhc_s_done) begin
        rsp_status <= status;
      end
      if (cyc.done && in_read) begin
        rsp_data <= cyc.rdata;
      end
    end
  end
endmodule // fhc_host

// file: bench/fhc_host_asserts.sv
`include "fhc_params.svh"

module fhc_host_asserts #(
  parameter int BUSY_MAX = 400
) (
  input wire logic                   clock,       // clock
  input wire logic                   rst,         // sync reset
  input wire logic                   cmd_valid,   // command offered
  input wire logic                   cmd_ready,   // command taken
  input wire fhc_pkg::fhc_op_type    cmd_op,      // command code
  input wire logic                   busy,        // command running
  input wire logic                   flash_ce_n,  // chip select
  input wire logic                   flash_oe_n,  // output enable
  input wire logic                   flash_we_n,  // write strobe
  input wire logic [`FHC_ADDR_W-1:0] flash_addr,  // address pins
  input wire logic                   flash_dq_oe  // data drive enable
);
  timeunit 1ns;
  timeprecision 1ps;

  // command taken at this edge
  wire take = cmd_valid && cmd_ready;

  // writes seen in a program, length of a busy span
  logic       prog_pend;
  logic [3:0] wr_cnt;
  int         busy_cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      prog_pend <= 1'b0;
      wr_cnt    <= 4'h0;
      busy_cnt  <= 0;
    end else begin
      prog_pend <= (take && cmd_op == fhc_pkg::fhc_op_prog) || (prog_pend && flash_oe_n);
      wr_cnt    <= take ? 4'h0 : wr_cnt + {3'h0, $fell(flash_we_n)};
      busy_cnt  <= busy ? busy_cnt + 1 : 0;
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);

  rd_hold_a: assert property (
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*3] ##1 flash_oe_n)
    else $error("read strobe width wrong");
  rd_addr_a: assert property (
    (!flash_oe_n && !$fell(flash_oe_n)) |-> $stable(flash_addr))
    else $error("address moved in a read");
  rd_start_a: assert property (
    (take && cmd_op == fhc_pkg::fhc_op_read) |-> ##2 $fell(flash_oe_n) && $fell(flash_ce_n))
    else $error("read did not start");
  wr_pulse_a: assert property (
    $fell(flash_we_n) |-> $fell(flash_ce_n) && flash_oe_n && flash_dq_oe
                          ##1 flash_we_n && flash_ce_n)
    else $error("write pulse shape wrong");
  no_clash_a: assert property (
    !flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("host drives data in a read");
  prog_four_a: assert property (
    (prog_pend && $fell(flash_oe_n)) |-> wr_cnt == 4'h4)
    else $error("program sequence not four writes");
  idle_quiet_a: assert property (
    !busy |-> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe)
    else $error("strobes active while idle");
  busy_bound_a: assert property (
    busy_cnt <= BUSY_MAX + 64)
    else $error("command ran past host budget");
endmodule // fhc_host_asserts

bind fhc_host fhc_host_asserts #(
  .BUSY_MAX(PROG_LIMIT > ERASE_LIMIT ? PROG_LIMIT : ERASE_LIMIT)
) i_asserts (
  .clock(clock),
  .rst(rst),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .cmd_op(cmd_op),
  .busy(busy),
  .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n),
  .flash_addr(flash_addr),
  .flash_dq_oe(flash_dq_oe)
);

// file: bench/fhc_flash_model.sv
`include "fhc_params.svh"

module fhc_flash_model #(
  parameter int PROG_MAX_NS = 8000
) (
  input  wire logic                   ce_n,       // chip select
  input  wire logic                   oe_n,       // output enable
  input  wire logic                   we_n,       // write strobe
  input  wire logic [`FHC_ADDR_W-1:0] addr,       // address
  input  wire logic [`FHC_DATA_W-1:0] dq_host,    // data from host
  input  wire logic                   dq_host_oe, // host drives data
  input  wire logic [31:0]            op_ns,      // embedded op time
  output logic [`FHC_DATA_W-1:0]      dq_dev      // data to host
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`FHC_DATA_W-1:0] mem [int];
  logic [`FHC_ADDR_W-1:0] pa;
  logic [`FHC_DATA_W-1:0] pdata = 8'h00;
  logic [`FHC_DATA_W-1:0] rd_val = 8'hff;
  logic [`FHC_DATA_W-1:0] last = 8'h00;
  logic                   busy = 1'b0;
  logic                   erasing = 1'b0;
  logic                   tog = 1'b0;
  logic                   to_flag = 1'b0;
  int                     step = 0;
  event                   go_prog;
  event                   go_erase;

  // command decode, sampled inside each write pulse
  always @(negedge we_n) begin
    #10;
    if (!ce_n && dq_host_oe && busy && to_flag && dq_host == 8'hf0) begin
      busy = 1'b0;
      to_flag = 1'b0;
    end else if (!ce_n && dq_host_oe && !busy) begin
      case (step)
        0, 3: step = (addr == `FHC_UNLOCK_A1 && dq_host == `FHC_UNLOCK_D1) ? step + 1 : 0;
        1, 4: step = (addr == `FHC_UNLOCK_A2 && dq_host == `FHC_UNLOCK_D2) ? step + 1 : 0;
        2: step = (dq_host == `FHC_PROG_CODE) ? 6 : (dq_host == 8'h80) ? 3 : 0;
        5: begin
          step = 0;
          if (dq_host == 8'h10 || dq_host == 8'h30) ->go_erase;
        end
        6: begin
          pa = addr;
          pdata = dq_host;
          step = 0;
          ->go_prog;
        end
        default: step = 0;
      endcase
    end
  end

  // embedded program, stuck with timeout flag when too slow
  always @(go_prog) begin
    busy = 1'b1;
    if (op_ns > PROG_MAX_NS) begin
      #(PROG_MAX_NS);
      to_flag = 1'b1;
    end else begin
      #(op_ns);
      mem[pa] = pdata;
      busy = 1'b0;
    end
  end

  // embedded erase, zero fill first
  always @(go_erase) begin
    busy = 1'b1;
    erasing = 1'b1;
    foreach (mem[k]) mem[k] = 8'h00;
    #(op_ns);
    mem.delete();
    busy = 1'b0;
    erasing = 1'b0;
  end

  // status or array data at each read strobe
  always @(negedge oe_n) begin
    #1;
    if (busy) begin
      tog = ~tog;
      rd_val = {erasing ? 1'b0 : ~pdata[7], tog, to_flag, 5'h00};
    end else begin
      rd_val = mem.exists(addr) ? mem[addr] : 8'hff;
    end
  end

  // released bus shows the inverse of the last value
  always @(posedge oe_n) last = rd_val;
  assign dq_dev = (!ce_n && !oe_n) ? rd_val : ~last;
endmodule // fhc_flash_model

// file: bench/tb.sv
`include "fhc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    fhc_pkg::fhc_op_type     op;
    logic [`FHC_ADDR_W-1:0]  a;
    logic [`FHC_DATA_W-1:0]  d;
    logic [31:0]             t;
    fhc_pkg::fhc_status_type st;
    logic [`FHC_DATA_W-1:0]  q;
  } fhc_row_type;

  logic                    clock;
  logic                    rst;
  logic                    cmd_valid;
  logic                    cmd_ready;
  fhc_pkg::fhc_op_type     cmd_op;
  logic [`FHC_ADDR_W-1:0]  cmd_addr;
  logic [`FHC_DATA_W-1:0]  cmd_data;
  logic                    rsp_valid;
  logic [`FHC_DATA_W-1:0]  rsp_data;
  fhc_pkg::fhc_status_type rsp_status;
  logic                    busy;
  logic                    ce_n;
  logic                    oe_n;
  logic                    we_n;
  logic [`FHC_ADDR_W-1:0]  f_addr;
  logic [`FHC_DATA_W-1:0]  dq_out;
  logic                    dq_oe;
  logic [`FHC_DATA_W-1:0]  dq_in;
  logic [31:0]             op_ns;
  int                      fail_count = 0;
  int                      cmp_count = 0;

  // ordinary commands and their results
  fhc_row_type rows [7] = '{
    '{fhc_pkg::fhc_op_read, 17'h00100, 8'h00, 0, fhc_pkg::fhc_st_ok, 8'hff},
    '{fhc_pkg::fhc_op_prog, 17'h00100, 8'ha5, 7000, fhc_pkg::fhc_st_ok, 8'ha5},
    '{fhc_pkg::fhc_op_read, 17'h00100, 8'h00, 0, fhc_pkg::fhc_st_ok, 8'ha5},
    '{fhc_pkg::fhc_op_prog, 17'h00101, 8'h3c, 1000, fhc_pkg::fhc_st_ok, 8'h3c},
    '{fhc_pkg::fhc_op_prog, 17'h00102, 8'h5a, 9000, fhc_pkg::fhc_st_dev_fail, 8'h00},
    '{fhc_pkg::fhc_op_write, 17'h00000, 8'hf0, 0, fhc_pkg::fhc_st_ok, 8'h00},
    '{fhc_pkg::fhc_op_read, 17'h00102, 8'h00, 0, fhc_pkg::fhc_st_ok, 8'hff}
  };
  logic [`FHC_ADDR_W-1:0] ea [6] = '{`FHC_UNLOCK_A1, `FHC_UNLOCK_A2, `FHC_UNLOCK_A1,
                                     `FHC_UNLOCK_A1, `FHC_UNLOCK_A2, `FHC_UNLOCK_A1};
  logic [`FHC_DATA_W-1:0] ed [6] = '{`FHC_UNLOCK_D1, `FHC_UNLOCK_D2, 8'h80,
                                     `FHC_UNLOCK_D1, `FHC_UNLOCK_D2, 8'h10};

  fhc_host #(.PROG_LIMIT(400), .ERASE_LIMIT(400)) i_dut (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_status(rsp_status), .busy(busy),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(f_addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in)
  );

  fhc_flash_model #(.PROG_MAX_NS(8000)) i_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .dq_host(dq_out),
    .dq_host_oe(dq_oe), .op_ns(op_ns), .dq_dev(dq_in)
  );

  // 50 ns clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // offer one command, hold it until taken, wait for the result
  task automatic run_cmd(input fhc_pkg::fhc_op_type op, input logic [16:0] a,
                         input logic [7:0] d);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("cmd_ready", {7'h0, cmd_ready}, 8'h00);
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clock);
    chk("rsp_valid", {7'h0, rsp_valid}, 8'h01);
  endtask

  task automatic chk_idle();
    chk("idle pins", {2'h0, ce_n, oe_n, we_n, dq_oe, cmd_ready, rsp_valid}, 8'h3a);
  endtask

  task automatic erase_seq(input logic [31:0] t);
    op_ns = t;
    for (int i = 0; i < 6; i++) run_cmd(fhc_pkg::fhc_op_write, ea[i], ed[i]);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog
  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = fhc_pkg::fhc_op_read;
    cmd_addr = '0;
    cmd_data = 8'h00;
    op_ns = 0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    chk_idle();
    foreach (rows[i]) begin
      op_ns = rows[i].t;
      run_cmd(rows[i].op, rows[i].a, rows[i].d);
      chk("status", {6'h0, rsp_status}, {6'h0, rows[i].st});
      if (rows[i].st == fhc_pkg::fhc_st_ok && rows[i].op != fhc_pkg::fhc_op_write)
        chk("data", rsp_data, rows[i].q);
    end
    // erase, poll to the end, area reads blank
    erase_seq(10000);
    run_cmd(fhc_pkg::fhc_op_poll, 17'h00101, 8'h00);
    chk("erase status", {6'h0, rsp_status}, 8'h00);
    chk("erase data", rsp_data, 8'hff);
    // erase longer than the host budget
    erase_seq(30000);
    run_cmd(fhc_pkg::fhc_op_poll, 17'h00100, 8'h00);
    chk("budget status", {6'h0, rsp_status}, {6'h0, fhc_pkg::fhc_st_host_to});
    repeat (700) @(negedge clock);
    // reset in the middle of a program
    op_ns = 7000;
    cmd_valid = 1'b1;
    cmd_op = fhc_pkg::fhc_op_prog;
    cmd_addr = 17'h00103;
    cmd_data = 8'hc3;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (60) @(negedge clock);
    rst = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    chk_idle();
    repeat (200) @(negedge clock);
    run_cmd(fhc_pkg::fhc_op_read, 17'h00103, 8'h00);
    chk("late data", rsp_data, 8'hc3);
    end_of_test();
  end
endmodule // tb
